// ==== tb/lcd_panel_model.sv ====
// Glass panel model that watches the common and segment drive lines.
`timescale 1ns/1ps
module lcd_panel_model (
	input  wire logic        ref_clk,         // Sampling clock.
	input  wire logic        resetn,          // Clears both flags.
	input  wire logic [7:0]  common_lines,    // Common drive.
	input  wire logic [21:0] segment_outputs, // Segment drive.
	output logic             multi_com,       // Two commons seen at once.
	output logic             stray_seg        // Segment driven, no common.
);
	// Two commons selected together would double-drive the glass, and a
	// segment driven while every common idles would leave DC on it.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			multi_com <= 1'b0;
			stray_seg <= 1'b0;
		end else begin
			if (!$onehot0(common_lines)) multi_com <= 1'b1;
			if (common_lines == 8'h00 && segment_outputs != '0) begin
				stray_seg <= 1'b1;
			end
		end
	end
endmodule : lcd_panel_model

// ==== tb/lcd_segment_common_driver_control_tb.sv ====
// Self-checking bench for the segment LCD controller.
`timescale 1ns/1ps
module lcd_segment_common_driver_control_tb;
	import lcd_pkg::*;
	logic         ref_clk, resetn, reg_bank1, reg_wr, multi_com, stray_seg;
	logic         watch_enable, frame_invert, contrast_enable;
	logic         watch_clock = 1'b0;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, common_lines;
	logic [175:0] display_data;
	logic [21:0]  segment_outputs;
	logic [3:0]   contrast_step;
	logic [1:0]   wcnt = 2'h0;
	bias_sel_t    bias_sel;
	int           error_cnt, compares;

	lcd_segment_common_driver_control DUT (.ref_clk(ref_clk),
		.resetn(resetn), .reg_bank1(reg_bank1), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.watch_clock(watch_clock), .watch_enable(watch_enable),
		.display_data(display_data), .common_lines(common_lines),
		.segment_outputs(segment_outputs), .frame_invert(frame_invert),
		.bias_sel(bias_sel), .contrast_step(contrast_step),
		.contrast_enable(contrast_enable));
	lcd_panel_model panel (.ref_clk(ref_clk), .resetn(resetn),
		.common_lines(common_lines), .segment_outputs(segment_outputs),
		.multi_com(multi_com), .stray_seg(stray_seg));

	// Clock at 125 MHz; the watch clock rises every eight cycles.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		wcnt <= wcnt + 2'h1;
		if (wcnt == 2'h3) watch_clock <= ~watch_clock;
	end

	task automatic chk(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask : chk

	task automatic wr(input logic b, input logic [7:0] a, d);
		@(posedge ref_clk);
		reg_bank1 <= b;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data is registered, so allow two edges after the address.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_bank1 <= 1'b1;
		reg_addr <= a;
		repeat (2) @(posedge ref_clk);
		#1 d = reg_rdata;
	endtask : rd

	// Counts cycles until the active common moves; a hang ends the run.
	task automatic wait_com(output int n);
		logic [7:0] prev;
		prev = common_lines;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
			if (n > 5000) begin
				$display("CHECK FAILED common step expected move seen none");
				error_cnt++;
				complete_run();
			end
		end while (common_lines === prev);
	endtask : wait_com

	function automatic logic [21:0] exp_seg(input int n);
		for (int i = 0; i < 22; i++) exp_seg[i] = display_data[8 * i + n];
	endfunction : exp_seg

	task automatic t_regs();
		logic [7:0] d;
		rd(CTRL_ADDR, d);
		chk("control reset", 8'h00, d);
		rd(MODE_ADDR, d);
		chk("mode reset", 8'h00, d);
		chk("commons at reset", 8'h00, common_lines);
		wr(1'b1, MODE_ADDR, 8'hff);
		rd(MODE_ADDR, d);
		chk("mode readback", 8'hf1, d);
		chk("contrast max", 5'h1f, {contrast_step, contrast_enable});
		wr(1'b1, MODE_ADDR, 8'h60);
		#1 chk("contrast off", 5'h0c, {contrast_step, contrast_enable});
		wr(1'b0, CTRL_ADDR, 8'h03);
		rd(CTRL_ADDR, d);
		chk("other bank", 8'h00, d);
		rd(8'hfb, d);
		chk("unmapped", 8'h00, d);
		wr(1'b1, CTRL_ADDR, 8'h5e);
		rd(CTRL_ADDR, d);
		chk("control rw", 8'h5e, d);
		$display("test registers done");
	endtask : t_regs

	// Walks one full scan plus the wrap for a duty code.
	task automatic t_duty(input logic [2:0] code);
		int         n;
		logic [2:0] last;
		bias_sel_t  bias;
		last = code[2] ? 3'h1 : (code == 0) ? 3'h7 : (code == 1) ? 3'h3 : 3'h2;
		bias = (code[2] || code == 3'h3) ? BIAS_HALF :
			(code == 3'h0) ? BIAS_QUARTER : BIAS_THIRD;
		wr(1'b1, CTRL_ADDR, {3'h4, code, 2'h3});
		repeat (2) @(posedge ref_clk);
		#1 chk("bias", bias, bias_sel);
		for (int p = 0; p <= last + 1; p++) begin
			chk("common", 8'h01 << (p % (last + 1)), common_lines);
			chk("segments", exp_seg(p % (last + 1)), segment_outputs);
			wait_com(n);
		end
		$display("test duty %0d done", code);
	endtask : t_duty

	// One whole phase lasts 2^(8-code) watch edges of eight cycles each.
	task automatic t_rate(input logic [2:0] code);
		int n;
		wr(1'b1, CTRL_ADDR, {code, 3'h4, 2'h3});
		repeat (3) @(posedge ref_clk);
		wait_com(n);
		wait_com(n);
		chk("phase length", (1 << (8 - code)) * 8, n);
		$display("test rate %0d done", code);
	endtask : t_rate

	task automatic t_modes();
		wr(1'b1, CTRL_ADDR, 8'h91);
		repeat (3) @(posedge ref_clk);
		#1 chk("dots off com", 8'h01, common_lines);
		chk("dots off seg", 22'h00_0000, segment_outputs);
		wr(1'b1, CTRL_ADDR, 8'h92);
		repeat (3) @(posedge ref_clk);
		#1 chk("dots on seg", 22'h3f_ffff, segment_outputs);
		// Code 101 is unavailable: with eight commons any guessed rate would
		// have stepped the scan well before two hundred cycles.
		wr(1'b1, CTRL_ADDR, 8'ha3);
		repeat (200) @(posedge ref_clk);
		#1 chk("frozen scan", 8'h01, common_lines);
		wr(1'b1, CTRL_ADDR, 8'h93);
		@(posedge ref_clk);
		watch_enable <= 1'b0;
		repeat (8) @(posedge ref_clk);
		#1 chk("no watch", 8'h00, common_lines);
		@(posedge ref_clk);
		watch_enable <= 1'b1;
		wr(1'b1, CTRL_ADDR, 8'h90);
		repeat (3) @(posedge ref_clk);
		#1 chk("display off", 30'h0, {common_lines, segment_outputs});
		$display("test modes done");
	endtask : t_modes

	// A rewrite of the same value must restart the scan and polarity.
	task automatic t_restart();
		int n;
		wr(1'b1, CTRL_ADDR, 8'h93);
		repeat (3) @(posedge ref_clk);
		repeat (3) wait_com(n);
		chk("after scan", 9'h102, {frame_invert, common_lines});
		wr(1'b1, CTRL_ADDR, 8'h93);
		repeat (3) @(posedge ref_clk);
		#1 chk("restarted", 9'h001, {frame_invert, common_lines});
		chk("common overlap", 1'b0, multi_com);
		chk("stray segment", 1'b0, stray_seg);
		$display("test restart done");
	endtask : t_restart

	// A reset in mid-run must clear both registers and stop the scan.
	task automatic t_reset();
		logic [7:0] d;
		wr(1'b1, MODE_ADDR, 8'h51);
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 chk("scan in reset", 9'h000, {frame_invert, common_lines});
		@(posedge ref_clk);
		resetn <= 1'b1;
		rd(CTRL_ADDR, d);
		chk("control after reset", 8'h00, d);
		rd(MODE_ADDR, d);
		chk("mode after reset", 8'h00, d);
		chk("contrast rst", 5'h00, {contrast_step, contrast_enable});
		$display("test reset done");
	endtask : t_reset

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	// Main sequence: reset for twenty cycles, then each scenario in turn.
	initial begin
		{resetn, reg_bank1, reg_wr, watch_enable} = '0;
		{reg_addr, reg_wdata, error_cnt, compares} = '0;
		for (int i = 0; i < 22; i++) display_data[8 * i +: 8] = 8'(i * 29 + 90);
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		watch_enable <= 1'b1;
		t_regs();
		for (int d = 0; d < 8; d++) t_duty(3'(d));
		for (int c = 0; c < 5; c++) t_rate(3'(c));
		t_modes();
		t_restart();
		t_reset();
		complete_run();
	end
endmodule : lcd_segment_common_driver_control_tb

// ==== verilog/lcd_pkg.sv ====
// Constants, field layouts and modes shared by the segment LCD controller.
package lcd_pkg;
	localparam logic [7:0] CTRL_ADDR     = 8'hf9; // Display control register.
	localparam logic [7:0] MODE_ADDR     = 8'hfa; // Contrast mode register.
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] MODE_WMASK    = 8'hf1; // Bits 3 to 1 hold no storage.
	localparam int         CLK_SEL_HI    = 7;
	localparam int         CLK_SEL_LO    = 5;
	localparam int         DUTY_HI       = 4;
	localparam int         DUTY_LO       = 2;
	localparam int         DISP_HI       = 1;
	localparam int         DISP_LO       = 0;
	localparam int         CONTRAST_HI   = 7;
	localparam int         CONTRAST_LO   = 4;
	localparam int         CONTRAST_EN   = 0;
	localparam logic [2:0] CLK_SEL_MAX   = 3'h4; // Codes above are unavailable.
	localparam logic [7:0] DIV_FULL      = 8'hff; // Divide by two to the eighth.
	localparam int         NUM_SEG       = 22;
	localparam int         NUM_COM       = 8;
	localparam int         RAM_BITS      = 8;

	// Display state selected by the low two control bits.
	typedef enum logic [1:0] {
		DISP_OFF    = 2'h0,
		DOTS_OFF    = 2'h1,
		DOTS_ON     = 2'h2,
		DISP_NORMAL = 2'h3
	} disp_mode_t;

	// Duty codes; any code with the top bit set means half duty.
	localparam logic [2:0] DUTY_EIGHTH   = 3'h0;
	localparam logic [2:0] DUTY_QUARTER  = 3'h1;
	localparam logic [2:0] DUTY_THIRD_A  = 3'h2;
	localparam logic [2:0] DUTY_THIRD_B  = 3'h3;

	// Bias ladder selection handed to the analog bias network.
	typedef enum logic [1:0] {
		BIAS_QUARTER = 2'h0,
		BIAS_THIRD   = 2'h1,
		BIAS_HALF    = 2'h2
	} bias_sel_t;

	// Last common phase index for each duty.
	localparam logic [2:0] LAST_EIGHTH   = 3'h7;
	localparam logic [2:0] LAST_QUARTER  = 3'h3;
	localparam logic [2:0] LAST_THIRD    = 3'h2;
	localparam logic [2:0] LAST_HALF     = 3'h1;
endpackage : lcd_pkg

// ==== verilog/lcd_segment_common_driver_control.sv ====
// Segment LCD controller: registers, frame divider, common scan, segments.
//
// How it works
// - Reset clears control: display off, eighth duty, slowest clock.
// - Control bits 7..5 divide the watch clock by 2^8 down to 2^4.
// - Bits 4..2 pick duty and bias; 1xx is half duty with half bias.
// - Control bits 1..0: off, all dots off, all dots on, normal.
// - Any control write restarts the divider and the common sequence.
// - The frame clock sets the rate at which commons are scanned.
// - Control register is read/write at F9h in bank one.
// - Reset clears mode: dimmest contrast, controller disabled.
// - Mode bits 7..4 pick one of sixteen rising contrast steps.
// - Mode bit 0 enables the contrast controller.
// - Duty decides how many commons are active: eight, four, three, two.
// - Each of the 22 segments takes data from its own RAM byte.
// - A RAM one drives select, a zero drives no-select.
// - Without the watch timer running the display logic stands still.
`timescale 1ns/1ps
module lcd_segment_common_driver_control #(
	parameter int SEGS = lcd_pkg::NUM_SEG, // Segment outputs.
	parameter int COMS = lcd_pkg::NUM_COM  // Common outputs.
) (
	input  wire logic                   ref_clk,         // System clock.
	input  wire logic                   resetn,          // Async reset.
	input  wire logic                   reg_bank1,       // Bank one selected.
	input  wire logic [7:0]             reg_addr,        // Register address.
	input  wire logic                   reg_wr,          // Write strobe.
	input  wire logic [7:0]             reg_wdata,       // Write data.
	output logic      [7:0]             reg_rdata,       // Read data.
	input  wire logic                   watch_clock,     // Watch clock pin.
	input  wire logic                   watch_enable,    // Watch timer on.
	input  wire logic [SEGS*8-1:0]      display_data,    // Display RAM bytes.
	output logic      [COMS-1:0]        common_lines,    // Active common.
	output logic      [SEGS-1:0]        segment_outputs, // Select levels.
	output logic                        frame_invert,    // AC drive phase.
	output lcd_pkg::bias_sel_t          bias_sel,        // Bias ladder pick.
	output logic      [3:0]             contrast_step,   // Contrast level.
	output logic                        contrast_enable  // Contrast on.
);
	import lcd_pkg::*;

	logic [7:0]      ctrl_reg;
	logic [7:0]      mode_reg;
	logic            ctrl_wr;
	logic            mode_wr;
	logic [2:0]      clk_sel;
	logic [2:0]      duty;
	disp_mode_t      disp;
	logic [2:0]      wclk_sync;
	logic [2:0]      wen_sync;
	logic            wclk_lvl;
	logic            wen_lvl;
	logic            watch_edge;
	logic            running;
	logic [7:0]      div_cnt;
	logic [7:0]      div_limit;
	logic            frame_tick;
	logic [2:0]      phase_reg;
	logic [2:0]      last_phase;
	logic [COMS-1:0] com_mask;
	logic [SEGS-1:0] seg_pick;
	logic            show_normal;

	// Register decode; only bank one addresses reach these registers.
	assign ctrl_wr = reg_wr && reg_bank1 && (reg_addr == CTRL_ADDR);
	assign mode_wr = reg_wr && reg_bank1 && (reg_addr == MODE_ADDR);
	assign clk_sel = ctrl_reg[CLK_SEL_HI:CLK_SEL_LO];
	assign duty    = ctrl_reg[DUTY_HI:DUTY_LO];
	assign disp    = disp_mode_t'(ctrl_reg[DISP_HI:DISP_LO]);

	// Control register, cleared by reset to a dark display.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= reg_wdata;
		end
	end

	// Mode register; reserved bits have no storage so they read as zero.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= MODE_RESET;
		end else if (mode_wr) begin
			mode_reg <= reg_wdata & MODE_WMASK;
		end
	end

	// Contrast level and enable go straight to the analog side.
	assign contrast_step   = mode_reg[CONTRAST_HI:CONTRAST_LO];
	assign contrast_enable = mode_reg[CONTRAST_EN];

	// Read data is registered; unmapped addresses read as zero.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_bank1 && reg_addr == CTRL_ADDR) begin
			reg_rdata <= ctrl_reg;
		end else if (reg_bank1 && reg_addr == MODE_ADDR) begin
			reg_rdata <= mode_reg;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// The watch clock and its enable come from another domain, so each goes
	// through three flops and only changes once the last two agree.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wclk_sync <= 3'h0;
			wen_sync  <= 3'h0;
		end else begin
			wclk_sync <= {wclk_sync[1:0], watch_clock};
			wen_sync  <= {wen_sync[1:0], watch_enable};
		end
	end

	// Filtered levels, updated only when the second and third flops agree.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wclk_lvl <= 1'b0;
			wen_lvl  <= 1'b0;
		end else begin
			if (wclk_sync[1] == wclk_sync[2]) begin
				wclk_lvl <= wclk_sync[2];
			end
			if (wen_sync[1] == wen_sync[2]) begin
				wen_lvl <= wen_sync[2];
			end
		end
	end

	assign watch_edge = wclk_sync[1] && wclk_sync[2] && !wclk_lvl;
	// Nothing runs without the watch timer or while the display is off.
	assign running    = wen_lvl && (disp != DISP_OFF);

	// Divider top: shifting the full count right by the code gives 2^(8-n)-1, a period of 2^(8-n).
	assign div_limit  = DIV_FULL >> clk_sel;
	// Unavailable codes stop the frame clock instead of guessing a rate.
	assign frame_tick = watch_edge && (clk_sel <= CLK_SEL_MAX) &&
		(div_cnt == div_limit);

	// Frame divider; a control write restarts it even with the same value.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= 8'h00;
		end else if (ctrl_wr || !running) begin
			div_cnt <= 8'h00;
		end else if (watch_edge) begin
			div_cnt <= (div_cnt >= div_limit) ? 8'h00 : div_cnt + 8'h01;
		end
	end

	// Number of commons in use and the last phase follow the duty code.
	always_comb begin
		last_phase = LAST_HALF;
		com_mask   = COMS'(8'h03);
		if (!duty[2]) begin
			unique case (duty)
				DUTY_EIGHTH: begin
					last_phase = LAST_EIGHTH;
					com_mask   = COMS'(8'hff);
				end
				DUTY_QUARTER: begin
					last_phase = LAST_QUARTER;
					com_mask   = COMS'(8'h0f);
				end
				default: begin
					last_phase = LAST_THIRD;
					com_mask   = COMS'(8'h07);
				end
			endcase
		end
	end

	// Common phase sequencer stepped by the frame clock.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg    <= 3'h0;
			frame_invert <= 1'b0;
		end else if (ctrl_wr || !running) begin
			phase_reg    <= 3'h0;
			frame_invert <= 1'b0;
		end else if (frame_tick) begin
			if (phase_reg >= last_phase) begin
				phase_reg    <= 3'h0;
				frame_invert <= !frame_invert;
			end else begin
				phase_reg <= phase_reg + 3'h1;
			end
		end
	end

	// Bias pick registered so the output comes from a flop.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bias_sel <= BIAS_QUARTER;
		end else if (duty[2] || duty == DUTY_THIRD_B) begin
			bias_sel <= BIAS_HALF;
		end else if (duty == DUTY_EIGHTH) begin
			bias_sel <= BIAS_QUARTER;
		end else begin
			bias_sel <= BIAS_THIRD;
		end
	end

	// Each segment reads bit n of its own byte during common phase n.
	always_comb begin
		seg_pick = '0;
		for (int i = 0; i < SEGS; i++) begin
			seg_pick[i] = display_data[i*RAM_BITS + phase_reg];
		end
	end

	assign show_normal = running && (disp == DISP_NORMAL);

	// Output stage: one common selected, segments select or no-select.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			common_lines    <= '0;
			segment_outputs <= '0;
		end else if (!running) begin
			common_lines    <= '0;
			segment_outputs <= '0;
		end else begin
			common_lines <= COMS'(1) << phase_reg;
			unique case (disp)
				DOTS_OFF:    segment_outputs <= '0;
				DOTS_ON:     segment_outputs <= '1;
				DISP_NORMAL: segment_outputs <= seg_pick;
				default:     segment_outputs <= '0;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	ctrl_restart_a: assert property (ctrl_wr |=> div_cnt == 8'h00 &&
		phase_reg == 3'h0)
		else $error("Control write did not restart divider and phase.");
	mode_reserved_a: assert property (mode_reg[3:1] == 3'h0)
		else $error("Reserved mode bits are not zero.");
	com_active_a: assert property (
		(common_lines & ~com_mask) == '0 || $past(ctrl_wr))
		else $error("Common outside the active duty set.");
	com_onehot_a: assert property (running && !ctrl_wr |=>
		$onehot(common_lines))
		else $error("Not exactly one common active.");
	watch_stop_a: assert property (!wen_lvl |=> common_lines == '0 &&
		segment_outputs == '0)
		else $error("Display ran without watch timer.");
	seg_data_a: assert property (show_normal |=>
		segment_outputs == $past(seg_pick))
		else $error("Segment data not taken from RAM bit of phase.");
	div_bound_a: assert property (
		div_cnt <= div_limit || $past(ctrl_wr))
		else $error("Frame divider passed its limit.");
	reset_clear_a: assert property ($rose(resetn) |->
		ctrl_reg == 8'h00 && mode_reg == 8'h00)
		else $error("Registers not cleared by reset.");
	read_ctrl_a: assert property (
		reg_bank1 && reg_addr == CTRL_ADDR && !ctrl_wr |=>
		reg_rdata == $past(ctrl_reg))
		else $error("Control register read back wrong.");
	half_bias_a: assert property (duty[2] |=> bias_sel == BIAS_HALF)
		else $error("Half duty did not pick half bias.");

	frame_tick_c: cover property (frame_tick);
	half_wrap_c:  cover property (duty[2] && frame_tick && phase_reg == 3'h1);
	dots_on_c:    cover property (running && disp == DOTS_ON);
	rewrite_c:    cover property (ctrl_wr && running);
endmodule : lcd_segment_common_driver_control
